/* core/icp_defines.svh */
`ifndef ICP_DEFINES_SVH
`define ICP_DEFINES_SVH
// target addresses selected by the 2-bit fuse
`define ICP_TGT_ADDR0     7'h22
`define ICP_TGT_ADDR1     7'h23
`define ICP_TGT_ADDR2     7'h24
`define ICP_TGT_ADDR3     7'h25
// register offsets
`define ICP_OFF_ID        8'h01
`define ICP_OFF_CC_SW     8'h02
`define ICP_OFF_TX_ROLE   8'h03
`define ICP_OFF_MEASURE   8'h04
`define ICP_OFF_SLICER    8'h05
`define ICP_OFF_GEN_A     8'h06
`define ICP_OFF_RX_CTL    8'h07
`define ICP_OFF_TOGGLE    8'h08
`define ICP_OFF_RETRY     8'h09
`define ICP_OFF_MASK_MAIN 8'h0A
`define ICP_OFF_POWER     8'h0B
`define ICP_OFF_SOFT_RST  8'h0C
`define ICP_OFF_OCP       8'h0D
`define ICP_OFF_MASK_A    8'h0E
`define ICP_OFF_MASK_B    8'h0F
`define ICP_OFF_TOG_EXIT  8'h10
`define ICP_OFF_RETRY_ST  8'h3C
`define ICP_OFF_TOG_ST    8'h3D
`define ICP_OFF_EV_A      8'h3E
`define ICP_OFF_EV_B      8'h3F
`define ICP_OFF_LINE_ST   8'h40
`define ICP_OFF_FIFO_ST   8'h41
`define ICP_OFF_EV_MAIN   8'h42
`define ICP_OFF_FIFO      8'h43
// reset values of writable registers and of the fifo status register
`define ICP_RST_TX_ROLE   8'h20
`define ICP_RST_MEASURE   8'h31
`define ICP_RST_SLICER    8'h60
`define ICP_RST_GEN_A     8'h24
`define ICP_RST_TOGGLE    8'h02
`define ICP_RST_RETRY     8'h06
`define ICP_RST_POWER     8'h01
`define ICP_RST_OCP       8'h0F
`define ICP_RST_FIFO_ST   8'h28
// self-clearing command bits
`define ICP_TX_FLUSH_BIT  6
`define ICP_TX_START_BIT  0
`define ICP_RX_FLUSH_BIT  2
`define ICP_SW_RES_BIT    0
// spike filter: one sample more than the longest spike can cover
`define ICP_SPIKE_NS      50
`define ICP_CLK_NS        8
`define ICP_FILT_CYC      (`ICP_SPIKE_NS / `ICP_CLK_NS + 2)
`endif

/* core/icp_pkg.sv */
`default_nettype none
package icp_pkg;
	// writable bank, element index = offset - 0x02
	typedef logic [14:0][7:0] icp_ctl_t;

	typedef struct packed {
		logic [7:0] retry_reset;
		logic [7:0] toggle_sop;
		logic [7:0] line;
		logic [7:0] fifo;
	} icp_stat_t;

	typedef struct packed {
		logic [7:0] flags_a;
		logic [7:0] flags_b;
		logic [7:0] flags_main;
	} icp_ev_t;

	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG,
		ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
	} icp_state_t;
endpackage
`default_nettype wire

/* core/icp_i2c_regs.sv */
`timescale 1ns/100ps
`default_nettype none
`include "icp_defines.svh"

module icp_i2c_regs #(
	parameter logic [3:0] DEV_CODE  = 4'h5, // arbitrary value
	parameter logic [1:0] PROD_CODE = 2'h0, // arbitrary value
	parameter logic [1:0] REV_CODE  = 2'h0  // arbitrary value
) (
	// clock and reset
	input  wire logic               CLK_SYS_I,
	input  wire logic               RST_B_I,
	// serial bus pins
	input  wire logic               SCL_I,
	input  wire logic               SDA_I,
	output logic                    SDA_O,
	output logic                    SDA_OE_O,
	// address strap
	input  wire logic [1:0]         FUSE_I,
	// device side
	output var icp_pkg::icp_ctl_t   CTRL_O,
	input  wire icp_pkg::icp_stat_t STAT_I,
	input  wire icp_pkg::icp_ev_t   EV_SET_I,
	output logic                    TX_PUSH_O,
	output logic [7:0]              TX_DATA_O,
	output logic                    RX_POP_O,
	input  wire logic [7:0]         RX_DATA_I
);
	localparam int unsigned FILT = `ICP_FILT_CYC;
	function automatic logic is_ctl(input logic [7:0] p);
		return (p >= `ICP_OFF_CC_SW) && (p <= `ICP_OFF_TOG_EXIT);
	endfunction
	function automatic logic [7:0] nxt_ptr(input logic [7:0] p);
		return (p == `ICP_OFF_FIFO) ? p : p + 8'h01;
	endfunction
	function automatic icp_pkg::icp_ctl_t ctl_rst();
		icp_pkg::icp_ctl_t r;
		r = '0;
		r[4'(`ICP_OFF_TX_ROLE - `ICP_OFF_CC_SW)] = `ICP_RST_TX_ROLE;
		r[4'(`ICP_OFF_MEASURE - `ICP_OFF_CC_SW)] = `ICP_RST_MEASURE;
		r[4'(`ICP_OFF_SLICER - `ICP_OFF_CC_SW)]  = `ICP_RST_SLICER;
		r[4'(`ICP_OFF_GEN_A - `ICP_OFF_CC_SW)]   = `ICP_RST_GEN_A;
		r[4'(`ICP_OFF_TOGGLE - `ICP_OFF_CC_SW)]  = `ICP_RST_TOGGLE;
		r[4'(`ICP_OFF_RETRY - `ICP_OFF_CC_SW)]   = `ICP_RST_RETRY;
		r[4'(`ICP_OFF_POWER - `ICP_OFF_CC_SW)]   = `ICP_RST_POWER;
		r[4'(`ICP_OFF_OCP - `ICP_OFF_CC_SW)]     = `ICP_RST_OCP;
		return r;
	endfunction
	// ******************************************
	// pin front end
	// ******************************************
	// index 1 is the serial clock, index 0 the data line
	logic [1:0]      sy1_q, sy1_d, sy2_q, sy2_d;
	logic [1:0]      flt_q, flt_d, prv_q, prv_d;
	logic [1:0][2:0] fc_q, fc_d;
	logic [1:0]      fz1_q, fz1_d, fz2_q, fz2_d;
	logic [6:0]      tgt_q, tgt_d;
	always_comb begin
		sy1_d = {SCL_I, SDA_I};
		sy2_d = sy1_q;
		prv_d = flt_q;
		flt_d = flt_q;
		fc_d  = fc_q;
		// a level is taken only once it held for FILT samples
		for (int i = 0; i < 2; i++) begin
			if (sy2_q[i] == flt_q[i]) begin
				fc_d[i] = 3'h0;
			end else if (fc_q[i] == 3'(FILT - 1)) begin
				flt_d[i] = sy2_q[i];
				fc_d[i]  = 3'h0;
			end else begin
				fc_d[i] = fc_q[i] + 3'h1;
			end
		end
		fz1_d = FUSE_I;
		fz2_d = fz1_q;
		case (fz2_q)
			2'h0:    tgt_d = `ICP_TGT_ADDR0;
			2'h1:    tgt_d = `ICP_TGT_ADDR1;
			2'h2:    tgt_d = `ICP_TGT_ADDR2;
			default: tgt_d = `ICP_TGT_ADDR3;
		endcase
	end
	always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			{sy1_q, sy2_q, flt_q, prv_q} <= 8'hFF;
			fc_q  <= '0;
			{fz1_q, fz2_q} <= 4'h0;
			tgt_q <= `ICP_TGT_ADDR0;
		end else begin
			{sy1_q, sy2_q, flt_q, prv_q} <= {sy1_d, sy2_d, flt_d, prv_d};
			fc_q  <= fc_d;
			{fz1_q, fz2_q} <= {fz1_d, fz2_d};
			tgt_q <= tgt_d;
		end
	end
	// 125 MHz leaves over 30 samples per half period at 1 MHz
	logic scl_rise, scl_fall, sda_f, start, stop;
	assign scl_rise = flt_q[1] & ~prv_q[1];
	assign scl_fall = ~flt_q[1] & prv_q[1];
	assign sda_f    = flt_q[0];
	assign start    = flt_q[1] & prv_q[1] & prv_q[0] & ~flt_q[0];
	assign stop     = flt_q[1] & prv_q[1] & ~prv_q[0] & flt_q[0];

	// ******************************************
	// protocol and register bank
	// ******************************************
	icp_pkg::icp_state_t st_q, st_d;
	icp_pkg::icp_ctl_t   ctl_q, ctl_d;
	icp_pkg::icp_stat_t  stat_q, stat_d;
	icp_pkg::icp_ev_t    fl_q, fl_d;
	logic [3:0]          cnt_q, cnt_d;
	logic [7:0]          sh_q, sh_d, ptr_q, ptr_d, txd_q, txd_d;
	logic                rw_q, rw_d, oe_q, oe_d;
	logic                push_q, push_d, pop_q, pop_d;
	logic [7:0]          rd_byte;
	logic [3:0]          idx;
	logic                load;
	assign idx = 4'(ptr_q - `ICP_OFF_CC_SW);
	always_comb begin
		case (ptr_q)
			`ICP_OFF_ID:       rd_byte = {DEV_CODE, PROD_CODE, REV_CODE};
			`ICP_OFF_RETRY_ST: rd_byte = stat_q.retry_reset;
			`ICP_OFF_TOG_ST:   rd_byte = stat_q.toggle_sop;
			`ICP_OFF_EV_A:     rd_byte = fl_q.flags_a;
			`ICP_OFF_EV_B:     rd_byte = fl_q.flags_b;
			`ICP_OFF_LINE_ST:  rd_byte = stat_q.line;
			`ICP_OFF_FIFO_ST:  rd_byte = stat_q.fifo;
			`ICP_OFF_EV_MAIN:  rd_byte = fl_q.flags_main;
			`ICP_OFF_FIFO:     rd_byte = RX_DATA_I;
			default:           rd_byte = is_ctl(ptr_q) ? ctl_q[idx] : 8'h00;
		endcase
	end
	always_comb begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		sh_d   = sh_q;
		ptr_d  = ptr_q;
		rw_d   = rw_q;
		oe_d   = oe_q;
		txd_d  = txd_q;
		push_d = 1'b0;
		pop_d  = 1'b0;
		load   = 1'b0;
		stat_d = STAT_I;
		fl_d   = fl_q | EV_SET_I;
		ctl_d  = ctl_q;
		if (ctl_q[4'(`ICP_OFF_SOFT_RST - `ICP_OFF_CC_SW)][`ICP_SW_RES_BIT]) begin
			ctl_d = ctl_rst();
		end
		// command bits act for one cycle and read back as zero
		ctl_d[4'(`ICP_OFF_GEN_A - `ICP_OFF_CC_SW)][`ICP_TX_FLUSH_BIT] = 1'b0;
		ctl_d[4'(`ICP_OFF_GEN_A - `ICP_OFF_CC_SW)][`ICP_TX_START_BIT] = 1'b0;
		ctl_d[4'(`ICP_OFF_RX_CTL - `ICP_OFF_CC_SW)][`ICP_RX_FLUSH_BIT] = 1'b0;
		ctl_d[4'(`ICP_OFF_SOFT_RST - `ICP_OFF_CC_SW)] = 8'h00;
		case (st_q)
			icp_pkg::ST_ADDR, icp_pkg::ST_REG, icp_pkg::ST_WR: begin
				if (scl_rise) begin
					sh_d  = {sh_q[6:0], sda_f};
					cnt_d = cnt_q + 4'h1;
				end else if (scl_fall && cnt_q == 4'h8) begin
					cnt_d = 4'h0;
					oe_d  = 1'b1;
					st_d  = icp_pkg::ST_WR_ACK;
					if (st_q == icp_pkg::ST_ADDR) begin
						if (sh_q[7:1] == tgt_q) begin
							rw_d = sh_q[0];
							st_d = icp_pkg::ST_ADDR_ACK;
						end else begin
							oe_d = 1'b0;
							st_d = icp_pkg::ST_IDLE;
						end
					end else if (st_q == icp_pkg::ST_REG) begin
						ptr_d = sh_q;
					end else begin
						ptr_d = nxt_ptr(ptr_q);
						if (ptr_q == `ICP_OFF_FIFO) begin
							push_d = 1'b1;
							txd_d  = sh_q;
						end else if (is_ctl(ptr_q)) begin
							ctl_d[idx] = sh_q;
						end
					end
				end
			end
			icp_pkg::ST_ADDR_ACK: begin
				if (scl_fall) begin
					if (rw_q) begin
						load = 1'b1;
						st_d = icp_pkg::ST_RD;
					end else begin
						oe_d = 1'b0;
						st_d = icp_pkg::ST_REG;
					end
				end
			end
			icp_pkg::ST_WR_ACK: begin
				if (scl_fall) begin
					oe_d = 1'b0;
					st_d = icp_pkg::ST_WR;
				end
			end
			icp_pkg::ST_RD: begin
				if (scl_rise) begin
					cnt_d = cnt_q + 4'h1;
				end else if (scl_fall && cnt_q == 4'h8) begin
					cnt_d = 4'h0;
					oe_d  = 1'b0;
					st_d  = icp_pkg::ST_RD_ACK;
				end else if (scl_fall) begin
					sh_d = {sh_q[6:0], 1'b0};
					oe_d = ~sh_q[6];
				end
			end
			icp_pkg::ST_RD_ACK: begin
				// rw doubles as the host's ack: low line means more
				if (scl_rise) begin
					rw_d = ~sda_f;
				end else if (scl_fall) begin
					if (rw_q) begin
						load = 1'b1;
						st_d = icp_pkg::ST_RD;
					end else begin
						st_d = icp_pkg::ST_IDLE;
					end
				end
			end
			default: ;
		endcase
		if (load) begin
			sh_d  = rd_byte;
			oe_d  = ~rd_byte[7];
			ptr_d = nxt_ptr(ptr_q);
			pop_d = (ptr_q == `ICP_OFF_FIFO);
			// clear only what was returned; a new event still lands
			case (ptr_q)
				`ICP_OFF_EV_A:    fl_d.flags_a    = EV_SET_I.flags_a;
				`ICP_OFF_EV_B:    fl_d.flags_b    = EV_SET_I.flags_b;
				`ICP_OFF_EV_MAIN: fl_d.flags_main = EV_SET_I.flags_main;
				default: ;
			endcase
		end
		if (start) begin
			st_d  = icp_pkg::ST_ADDR;
			cnt_d = 4'h0;
			oe_d  = 1'b0;
		end else if (stop) begin
			st_d = icp_pkg::ST_IDLE;
			oe_d = 1'b0;
		end
	end
	always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			st_q   <= icp_pkg::ST_IDLE;
			{cnt_q, sh_q, ptr_q, rw_q, oe_q, txd_q, push_q, pop_q} <= 32'h0;
			ctl_q  <= ctl_rst();
			stat_q <= '{8'h00, 8'h00, 8'h00, `ICP_RST_FIFO_ST};
			fl_q   <= '0;
		end else begin
			st_q   <= st_d;
			{cnt_q, sh_q, ptr_q, rw_q, oe_q, txd_q, push_q, pop_q} <=
				{cnt_d, sh_d, ptr_d, rw_d, oe_d, txd_d, push_d, pop_d};
			ctl_q  <= ctl_d;
			stat_q <= stat_d;
			fl_q   <= fl_d;
		end
	end
	assign SDA_O     = 1'b0;
	assign SDA_OE_O  = oe_q;
	assign CTRL_O    = ctl_q;
	assign TX_PUSH_O = push_q;
	assign TX_DATA_O = txd_q;
	assign RX_POP_O  = pop_q;

	// ******************************************
	// assertions
	// ******************************************
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_B_I);
	addr_ack_a: assert property (
		(st_q == icp_pkg::ST_ADDR && scl_fall && cnt_q == 4'h8 &&
			sh_q[7:1] == tgt_q) |=> (oe_q && st_q == icp_pkg::ST_ADDR_ACK))
		else $error("own address not acknowledged");
	addr_nack_a: assert property (
		(st_q == icp_pkg::ST_ADDR && scl_fall && cnt_q == 4'h8 &&
			sh_q[7:1] != tgt_q) |=> (!oe_q && st_q == icp_pkg::ST_IDLE))
		else $error("foreign address acknowledged");
	spike_filter_a: assert property (
		$changed(flt_q[1]) |-> $past(sy2_q[1], 8) == flt_q[1])
		else $error("clock level taken before filter time");
	fifo_push_a: assert property (
		(st_q == icp_pkg::ST_WR && scl_fall && cnt_q == 4'h8 &&
			ptr_q == `ICP_OFF_FIFO) |=>
			(TX_PUSH_O && TX_DATA_O == $past(sh_q)) ##1 !TX_PUSH_O)
		else $error("fifo port write not pushed once");
	fifo_pop_a: assert property (
		(load && ptr_q == `ICP_OFF_FIFO) |=> RX_POP_O ##1 !RX_POP_O)
		else $error("fifo port read not popped once");
	ptr_hold_a: assert property (
		(TX_PUSH_O || RX_POP_O) |-> ptr_q == `ICP_OFF_FIFO)
		else $error("pointer left the fifo port");
	ptr_step_a: assert property (
		(load && ptr_q != `ICP_OFF_FIFO) |=> ptr_q == $past(ptr_q) + 8'h01)
		else $error("pointer did not advance after read");
	reset_vals_a: assert property (
		!$past(RST_B_I) |-> (ctl_q == ctl_rst() &&
			stat_q.fifo == `ICP_RST_FIFO_ST))
		else $error("register reset value wrong");
	id_read_a: assert property (
		(load && ptr_q == `ICP_OFF_ID) |=>
			(sh_q == {DEV_CODE, PROD_CODE, REV_CODE} && oe_q == !DEV_CODE[3]))
		else $error("identification byte wrong");
	read_clear_a: assert property (
		(load && ptr_q == `ICP_OFF_EV_MAIN) |=>
			fl_q.flags_main == $past(EV_SET_I.flags_main))
		else $error("event flags not cleared by read");
	set_wins_a: assert property (
		(EV_SET_I.flags_a != 8'h00) |=>
			(fl_q.flags_a & $past(EV_SET_I.flags_a)) == $past(EV_SET_I.flags_a))
		else $error("event lost against clear");
	reg_write_c: cover property (st_q == icp_pkg::ST_WR && scl_fall &&
		cnt_q == 4'h8 && is_ctl(ptr_q));
	// bytes lie over a thousand cycles apart, so the burst is seen at the ack
	fifo_burst_c: cover property (st_q == icp_pkg::ST_RD_ACK && scl_fall &&
		rw_q && ptr_q == `ICP_OFF_FIFO);
	read_nack_c: cover property (st_q == icp_pkg::ST_RD_ACK && scl_fall && !rw_q);
endmodule
`default_nettype wire

/* dv/icp_host_bfm.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************
// serial bus host
// ****************
module icp_host_bfm (
	// bus pins
	output logic      scl_o,
	output logic      sda_oe_o,
	input  wire logic sda_i
);
	// quarter of a 1040 ns bit period, just under 1000 kHz; a faster clock
	// leaves no low phase for the filtered ack to settle in
	localparam int Q = 260;
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end
	// waits out the target's ack before raising scl, so it also repeats
	task automatic start();
		#(2*Q) sda_oe_o = 1'b0;
		#Q scl_o = 1'b1;
		#Q sda_oe_o = 1'b1;
		#Q scl_o = 1'b0;
	endtask
	task automatic stop();
		#Q sda_oe_o = 1'b1;
		#Q scl_o = 1'b1;
		#Q sda_oe_o = 1'b0;
		#(4*Q);
	endtask
	// sampled late in the high phase: the target answers ~90 ns after the fall
	task automatic bit_io(input logic b, output logic r);
		#Q sda_oe_o = ~b;
		#Q scl_o = 1'b1;
		#(2*Q-10) r = sda_i;
		#10 scl_o = 1'b0;
	endtask
	task automatic xfer(input logic [7:0] d, input logic ai,
		output logic [7:0] q, output logic ao);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(ai, ao);
	endtask
	// 40 ns high pulse, short enough that the target must ignore it
	task automatic spike();
		#Q scl_o = 1'b1;
		#40 scl_o = 1'b0;
	endtask
endmodule
`default_nettype wire

/* dv/tb_i2c_register_map_port.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_i2c_register_map_port;
	logic              clk, rst_b, scl, sda, sda_o, sda_oe, h_oe, ack;
	logic              tx_push, rx_pop;
	logic [1:0]        fuse;
	logic [7:0]        tx_data, rx_q, tgt, q;
	logic [7:0]        rb [0:22];
	logic [7:0]        txq [$];
	icp_pkg::icp_ctl_t  ctrl;
	icp_pkg::icp_stat_t stat;
	icp_pkg::icp_ev_t   ev;
	int                miscompares, n_tests, n_pop;
	// id 0x50 is the arbitrary code of the default parameters
	logic [7:0] exp [0:22] = '{8'h50, 8'h00, 8'h20, 8'h31, 8'h60, 8'h24,
		8'h00, 8'h02, 8'h06, 8'h00, 8'h01, 8'h00, 8'h0F, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h28, 8'h00};
	logic [7:0] evx [0:9] = '{8'h12, 8'h01, 8'h00, 8'h28, 8'h81,
		8'h00, 8'h00, 8'h00, 8'h28, 8'h00};

	// pulled-up open-drain wire
	assign sda = !((sda_oe && !sda_o) || h_oe);
	icp_host_bfm u_icp_host_bfm (.scl_o(scl), .sda_oe_o(h_oe), .sda_i(sda));
	icp_i2c_regs u_icp_i2c_regs (.CLK_SYS_I(clk), .RST_B_I(rst_b),
		.SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe),
		.FUSE_I(fuse), .CTRL_O(ctrl), .STAT_I(stat), .EV_SET_I(ev),
		.TX_PUSH_O(tx_push), .TX_DATA_O(tx_data), .RX_POP_O(rx_pop),
		.RX_DATA_I(rx_q));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// receive fifo stand-in and transmit capture
	always @(posedge clk) begin
		if (rx_pop) begin
			rx_q <= rx_q + 8'h01;
			n_pop <= n_pop + 1;
		end
		if (tx_push) txq.push_back(tx_data);
	end

	// ****************
	// access tasks
	// ****************
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic probe(input logic [7:0] a, input logic e);
		u_icp_host_bfm.start();
		u_icp_host_bfm.xfer({a[6:0], 1'b0}, 1'b1, q, ack);
		chk({7'h00, ack}, {7'h00, e});
		u_icp_host_bfm.stop();
	endtask
	task automatic hdr(input logic [7:0] off);
		u_icp_host_bfm.start();
		u_icp_host_bfm.xfer({tgt[6:0], 1'b0}, 1'b1, q, ack);
		chk({7'h00, ack}, 8'h00);
		u_icp_host_bfm.xfer(off, 1'b1, q, ack);
		chk({7'h00, ack}, 8'h00);
	endtask
	task automatic wr(input logic [7:0] off, input logic [7:0] d,
		input int n, input logic g);
		hdr(off);
		if (g) u_icp_host_bfm.spike();
		for (int i = 0; i < n; i++) begin
			u_icp_host_bfm.xfer(d + 8'(i), 1'b1, q, ack);
			chk({7'h00, ack}, 8'h00);
		end
		u_icp_host_bfm.stop();
	endtask
	task automatic rd(input logic [7:0] off, input int n);
		hdr(off);
		u_icp_host_bfm.start();
		u_icp_host_bfm.xfer({tgt[6:0], 1'b1}, 1'b1, q, ack);
		chk({7'h00, ack}, 8'h00);
		for (int i = 0; i < n; i++) begin
			u_icp_host_bfm.xfer(8'hFF, i == n - 1, rb[i], ack);
		end
		u_icp_host_bfm.stop();
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ****************
	// tests
	// ****************
	initial begin
		#800000;
		miscompares++;
		$display("Error at %0t: run limit reached", $time);
		test_done();
	end
	initial begin
		rst_b = 1'b0;
		fuse = 2'b00;
		stat = '{8'h00, 8'h00, 8'h00, 8'h28};
		ev = '0;
		rx_q = 8'h40;
		n_pop = 0;
		tgt = 8'h22;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		repeat (10) @(posedge clk);
		rd(8'h01, 16);
		for (int i = 0; i < 16; i++) chk(rb[i], exp[i]);
		rd(8'h3C, 7);
		for (int i = 0; i < 7; i++) chk(rb[i], exp[16 + i]);
		$display("test reset_values done");
		wr(8'h0A, 8'hA5, 1, 1'b1);
		rd(8'h0A, 1);
		chk(rb[0], 8'hA5);
		chk(ctrl[8], 8'hA5);
		$display("test write_readback done");
		wr(8'h0C, 8'h01, 1, 1'b0);
		chk(ctrl[8], 8'h00);
		chk(ctrl[10], 8'h00);
		$display("test soft_reset done");
		wr(8'h43, 8'hC0, 3, 1'b0);
		chk(8'(txq.size()), 8'h03);
		foreach (txq[i]) chk(txq[i], 8'hC0 + 8'(i));
		rd(8'h43, 3);
		for (int i = 0; i < 3; i++) chk(rb[i], 8'h40 + 8'(i));
		chk(8'(n_pop), 8'h03);
		$display("test fifo_port done");
		@(posedge clk);
		ev <= '{8'h12, 8'h01, 8'h81};
		@(posedge clk);
		ev <= '0;
		for (int k = 0; k < 2; k++) begin
			rd(8'h3E, 5);
			for (int i = 0; i < 5; i++) chk(rb[i], evx[5*k + i]);
		end
		$display("test event_flags done");
		for (int f = 0; f < 4; f++) begin
			@(posedge clk);
			fuse <= 2'(f);
			repeat (8) @(posedge clk);
			probe(8'h22 + 8'(f), 1'b0);
			probe(8'h22 + 8'((f + 1) % 4), 1'b1);
		end
		$display("test address_strap done");
		test_done();
	end
endmodule
`default_nettype wire
